/* File: bfps_pkg.sv */
// package of constants for the buck fault protection sequencer
package bfps_pkg;
  // ----------------------------------------
  // channel counts
  // ----------------------------------------
  localparam int BFPS_SW_CHANNELS = 3;
  localparam int BFPS_ALL_OUTPUTS = 4;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int BFPS_CLOCK_HZ = 50000000;
  localparam int BFPS_SOFT_START_US = 1700;
  localparam int BFPS_SOFT_START_CYCLES = BFPS_SOFT_START_US * (BFPS_CLOCK_HZ / 1000000);
  localparam int BFPS_OC_CONSECUTIVE = 2;
  localparam int BFPS_HICCUP_PASSES = 4;
  localparam int BFPS_OV_MODULATE_CYCLES = 2;
  // ----------------------------------------
  // levels and reset values
  // ----------------------------------------
  localparam int BFPS_OV_LEVEL_PERCENT = 118;
  localparam int BFPS_OT_TRIP_CELSIUS = 150;
  localparam int BFPS_OT_RESUME_CELSIUS = 130;
  localparam logic BFPS_POWER_GOOD_OUT_RESET = 1'h0;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    BFPS_OFF,
    BFPS_SOFT_START,
    BFPS_RUN,
    BFPS_HICCUP,
    BFPS_THERMAL
  } bfps_state_type;
endpackage

/* File: bfps_sequencer.sv */
// fault protection sequencer for a multi-channel synchronous buck controller
`timescale 1ns/1ps
// Contract
// - persistent overload drops power good, starts hiccup
// - lockout holds reset, shuts device down
// - all channels disabled during lockout
// - power good driven low during lockout
// - per-cycle lower switch overcurrent compare
// - two consecutive overcurrents: gates off, soft-start
// - hiccup passes soft-start four times first
// - hiccup repeats while overcurrent persists
// - overcurrent detection armed during soft-start
// - overvoltage flagged above 118 percent
// - overvoltage: upper off, lower modulates two cycles
// - persistent overvoltage: lower held on
// - shut down at 150 C indication
// - resume below 130 C via soft-start
// - fixed soft-start duration of 1.7 ms
// - power good after soft-start and regulation
module bfps_sequencer
  import bfps_pkg::*;
#(
  parameter int SOFT_START_CYCLES = BFPS_SOFT_START_CYCLES,
  parameter int SW_CHANNELS = BFPS_SW_CHANNELS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic supply_lockout,
  input wire logic [SW_CHANNELS-1:0] switching_cycle_tick,
  input wire logic [SW_CHANNELS-1:0] overcurrent_compare,
  input wire logic [SW_CHANNELS-1:0] overvoltage_compare,
  input wire logic over_temp_trip,
  input wire logic over_temp_cool,
  input wire logic [BFPS_ALL_OUTPUTS-1:0] output_in_regulation,
  input wire logic [SW_CHANNELS-1:0] pwm_request,
  output logic [SW_CHANNELS-1:0] upper_gate,
  output logic [SW_CHANNELS-1:0] lower_gate,
  output logic linear_enable,
  output logic soft_start_active,
  output logic power_good_out
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  localparam int SS_W = $clog2(SOFT_START_CYCLES + 1);
  // refused while building, so a bad count never reaches the timer logic
  if (SOFT_START_CYCLES < 1) begin : g_bad_soft_start
    $error("soft start count must be at least one");
  end
  if (SW_CHANNELS < 1) begin : g_bad_channels
    $error("at least one switching channel needed");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int SYNC_W = 1 + 3 * SW_CHANNELS + 2 + BFPS_ALL_OUTPUTS;
  // lockout bit is the top one; it leaves reset asserted
  localparam logic [SYNC_W-1:0] SYNC_RESET = {1'b1, {(SYNC_W-1){1'b0}}};
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync1_next;
  logic [SYNC_W-1:0] sync2_next;
  logic lockout_s;
  logic [SW_CHANNELS-1:0] tick_s;
  logic [SW_CHANNELS-1:0] oc_s;
  logic [SW_CHANNELS-1:0] ov_s;
  logic ot_trip_s;
  logic ot_cool_s;
  logic [BFPS_ALL_OUTPUTS-1:0] in_reg_s;

  // first stage is read only by the second stage
  always_comb begin
    sync1_next = {supply_lockout, switching_cycle_tick, overcurrent_compare,
                  overvoltage_compare, over_temp_trip, over_temp_cool,
                  output_in_regulation};
    sync2_next = sync1_reg;
  end

  // lockout syncs to asserted so the block starts disabled
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign {lockout_s, tick_s, oc_s, ov_s, ot_trip_s, ot_cool_s, in_reg_s} = sync2_reg;

  // ----------------------------------------
  // tick edge detection
  // ----------------------------------------
  logic [SW_CHANNELS-1:0] tick_d_reg;
  logic [SW_CHANNELS-1:0] tick_d_next;
  logic [SW_CHANNELS-1:0] cycle_end;

  // one pulse per switching cycle at the rising tick edge
  always_comb begin
    tick_d_next = tick_s;
    cycle_end = tick_s & ~tick_d_reg;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tick_d_reg <= '0;
    end else begin
      tick_d_reg <= tick_d_next;
    end
  end

  // ----------------------------------------
  // per-channel overcurrent and overvoltage
  // ----------------------------------------
  logic [SW_CHANNELS-1:0][1:0] oc_count_reg;
  logic [SW_CHANNELS-1:0][1:0] oc_count_next;
  logic [SW_CHANNELS-1:0][1:0] ov_count_reg;
  logic [SW_CHANNELS-1:0][1:0] ov_count_next;
  logic [SW_CHANNELS-1:0] oc_trip;
  logic [SW_CHANNELS-1:0] ov_clamp;
  logic [SW_CHANNELS-1:0] ov_modulate;
  logic channels_off;

  // overcurrent compare sampled at each cycle end; count clean cycles as resets
  always_comb begin
    for (int i = 0; i < SW_CHANNELS; i++) begin
      oc_count_next[i] = oc_count_reg[i];
      ov_count_next[i] = ov_count_reg[i];
      oc_trip[i] = 1'b0;
      if (channels_off) begin
        oc_count_next[i] = 2'h0;
      end else if (cycle_end[i]) begin
        if (oc_s[i]) begin
          if (oc_count_reg[i] == 2'(BFPS_OC_CONSECUTIVE - 1)) begin
            oc_trip[i] = 1'b1;
            oc_count_next[i] = 2'h0;
          end else begin
            oc_count_next[i] = oc_count_reg[i] + 2'h1;
          end
        end else begin
          oc_count_next[i] = 2'h0;
        end
      end
      // overvoltage: count modulated cycles, saturate at the clamp point
      if (!ov_s[i] || channels_off) begin
        ov_count_next[i] = 2'h0;
      end else if (cycle_end[i] && ov_count_reg[i] != 2'(BFPS_OV_MODULATE_CYCLES)) begin
        ov_count_next[i] = ov_count_reg[i] + 2'h1;
      end
      ov_modulate[i] = ov_s[i] && ov_count_reg[i] != 2'(BFPS_OV_MODULATE_CYCLES);
      ov_clamp[i] = ov_s[i] && ov_count_reg[i] == 2'(BFPS_OV_MODULATE_CYCLES);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      oc_count_reg <= '0;
      ov_count_reg <= '0;
    end else begin
      oc_count_reg <= oc_count_next;
      ov_count_reg <= ov_count_next;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  bfps_state_type state_reg;
  bfps_state_type state_next;
  logic [SS_W-1:0] ss_count_reg;
  logic [SS_W-1:0] ss_count_next;
  logic [2:0] pass_reg;
  logic [2:0] pass_next;
  logic oc_seen_reg;
  logic oc_seen_next;
  logic power_good_out_reg;
  logic power_good_out_next;
  logic ss_done;

  assign ss_done = ss_count_reg == SS_W'(SOFT_START_CYCLES - 1);

  // lockout and thermal override everything; hiccup reuses the soft-start timer
  always_comb begin
    state_next = state_reg;
    ss_count_next = ss_count_reg;
    pass_next = pass_reg;
    oc_seen_next = oc_seen_reg;
    power_good_out_next = 1'b0;
    if (lockout_s) begin
      state_next = BFPS_OFF;
      ss_count_next = '0;
      pass_next = 3'h0;
    end else if (ot_trip_s) begin
      state_next = BFPS_THERMAL;
      ss_count_next = '0;
      pass_next = 3'h0;
    end else begin
      case (state_reg)
        BFPS_OFF: begin
          state_next = BFPS_SOFT_START;
          ss_count_next = '0;
        end
        BFPS_SOFT_START: begin
          if (|oc_trip) begin
            state_next = BFPS_HICCUP;
            ss_count_next = '0;
            pass_next = 3'h0;
            oc_seen_next = 1'b0;
          end else if (ss_done) begin
            state_next = BFPS_RUN;
          end else begin
            ss_count_next = ss_count_reg + SS_W'(1);
          end
        end
        BFPS_RUN: begin
          if (|oc_trip) begin
            state_next = BFPS_HICCUP;
            ss_count_next = '0;
            pass_next = 3'h0;
            oc_seen_next = 1'b0;
          end else begin
            power_good_out_next = &in_reg_s;
          end
        end
        BFPS_HICCUP: begin
          if (|oc_s) begin
            oc_seen_next = 1'b1; // persistence seen while gates are off
          end
          if (ss_done) begin
            ss_count_next = '0;
            if (pass_reg == 3'(BFPS_HICCUP_PASSES - 1)) begin
              pass_next = 3'h0;
              oc_seen_next = 1'b0;
              if (!(oc_seen_reg || (|oc_s))) begin
                state_next = BFPS_SOFT_START;
              end // else another four passes
            end else begin
              pass_next = pass_reg + 3'h1;
            end
          end else begin
            ss_count_next = ss_count_reg + SS_W'(1);
          end
        end
        BFPS_THERMAL: begin
          if (ot_cool_s) begin
            state_next = BFPS_SOFT_START;
            ss_count_next = '0;
          end
        end
        default: begin
          state_next = BFPS_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= BFPS_OFF;
      ss_count_reg <= '0;
      pass_reg <= 3'h0;
      oc_seen_reg <= 1'b0;
      power_good_out_reg <= BFPS_POWER_GOOD_OUT_RESET;
    end else begin
      state_reg <= state_next;
      ss_count_reg <= ss_count_next;
      pass_reg <= pass_next;
      oc_seen_reg <= oc_seen_next;
      power_good_out_reg <= power_good_out_next;
    end
  end

  // ----------------------------------------
  // gate drive outputs
  // ----------------------------------------
  logic [SW_CHANNELS-1:0] upper_next;
  logic [SW_CHANNELS-1:0] lower_next;
  logic [SW_CHANNELS-1:0] upper_reg;
  logic [SW_CHANNELS-1:0] lower_reg;
  logic linear_reg;
  logic linear_next;

  // both gates low whenever the sequencer is not switching
  assign channels_off = lockout_s || state_reg == BFPS_OFF ||
                        state_reg == BFPS_HICCUP || state_reg == BFPS_THERMAL;

  // one register stage; a simultaneous high on both gates is never produced
  always_comb begin
    linear_next = !channels_off;
    for (int i = 0; i < SW_CHANNELS; i++) begin
      if (channels_off) begin
        upper_next[i] = 1'b0;
        lower_next[i] = 1'b0;
      end else if (ov_clamp[i]) begin
        upper_next[i] = 1'b0;
        lower_next[i] = 1'b1;
      end else if (ov_modulate[i]) begin
        upper_next[i] = 1'b0;
        lower_next[i] = !pwm_request[i];
      end else begin
        upper_next[i] = pwm_request[i];
        lower_next[i] = !pwm_request[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      upper_reg <= '0;
      lower_reg <= '0;
      linear_reg <= 1'b0;
    end else begin
      upper_reg <= upper_next;
      lower_reg <= lower_next;
      linear_reg <= linear_next;
    end
  end

  assign upper_gate = upper_reg;
  assign lower_gate = lower_reg;
  assign linear_enable = linear_reg;
  assign soft_start_active = state_reg == BFPS_SOFT_START || state_reg == BFPS_HICCUP;
  assign power_good_out = power_good_out_reg;
endmodule // bfps_sequencer

/* File: bfps_sequencer_chk.sv */
// checker of the sequencer port behaviour
`timescale 1ns/1ps
module bfps_sequencer_chk
  import bfps_pkg::*;
#(
  parameter int SOFT_START_CYCLES = BFPS_SOFT_START_CYCLES,
  parameter int SW_CHANNELS = BFPS_SW_CHANNELS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic supply_lockout,
  input wire logic [SW_CHANNELS-1:0] overcurrent_compare,
  input wire logic [SW_CHANNELS-1:0] overvoltage_compare,
  input wire logic over_temp_trip,
  input wire logic [BFPS_ALL_OUTPUTS-1:0] output_in_regulation,
  input wire logic [SW_CHANNELS-1:0] upper_gate,
  input wire logic [SW_CHANNELS-1:0] lower_gate,
  input wire logic linear_enable,
  input wire logic soft_start_active,
  input wire logic power_good_out
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  logic ss_reg, ss_next, run;
  logic [17:0] len_reg, len_next;
  logic [4:0] oc_reg, oc_next, ov_reg, ov_next;
  // soft-start run length and saturating fault ages; counts avoid long repetitions
  always_comb begin
    run = linear_enable && !soft_start_active;
    ss_next = soft_start_active;
    len_next = !soft_start_active ? len_reg : ss_reg ? len_reg + {17'h0, ~&len_reg} : 18'h1;
    oc_next = overcurrent_compare[0] ? oc_reg + {4'h0, ~&oc_reg} : 5'h0;
    if (supply_lockout || over_temp_trip) begin
      oc_next = 5'h0;
    end
    ov_next = overvoltage_compare[0] ? ov_reg + {4'h0, ~&ov_reg} : 5'h0;
  end
  always_ff @(posedge clock) begin
    ss_reg <= rstn ? ss_next : 1'h0;
    len_reg <= rstn ? len_next : 18'h0;
    oc_reg <= rstn ? oc_next : 5'h0;
    ov_reg <= rstn ? ov_next : 5'h0;
  end
  property p_lockout_off;
    supply_lockout [*5] |-> !power_good_out && !linear_enable && (upper_gate | lower_gate) == '0;
  endproperty
  a_lockout_off: assert property (p_lockout_off)
    else $error("outputs active in lockout");
  property p_pg_only_run;
    power_good_out |-> run;
  endproperty
  a_pg_only_run: assert property (p_pg_only_run)
    else $error("power good outside run");
  property p_pg_after_ss;
    $rose(power_good_out) |-> len_reg >= SOFT_START_CYCLES;
  endproperty
  a_pg_after_ss: assert property (p_pg_after_ss)
    else $error("power good before full soft-start");
  property p_pg_needs_reg;
    (output_in_regulation != 4'hF) [*4] |-> !power_good_out;
  endproperty
  a_pg_needs_reg: assert property (p_pg_needs_reg)
    else $error("power good without regulation");
  property p_oc_hiccup;
    oc_reg >= 5'h14 |-> !power_good_out && (upper_gate | lower_gate) == '0;
  endproperty
  a_oc_hiccup: assert property (p_oc_hiccup)
    else $error("overload did not stop drive");
  property p_ov_upper;
    ov_reg >= 5'h5 |-> !upper_gate[0];
  endproperty
  a_ov_upper: assert property (p_ov_upper)
    else $error("upper drive on in overvoltage");
  property p_ov_lower;
    run && ov_reg >= 5'h18 |-> lower_gate[0];
  endproperty
  a_ov_lower: assert property (p_ov_lower)
    else $error("lower drive not held in overvoltage");
  property p_thermal_off;
    over_temp_trip [*5] |-> !power_good_out && !linear_enable && (upper_gate | lower_gate) == '0;
  endproperty
  a_thermal_off: assert property (p_thermal_off)
    else $error("outputs active while hot");
  c_pg_up: cover property ($rose(power_good_out));
  c_hiccup: cover property (oc_reg == 5'h14);
  c_ov_held: cover property (run && ov_reg == 5'h18);
endmodule // bfps_sequencer_chk
bind bfps_sequencer bfps_sequencer_chk #(
  .SOFT_START_CYCLES(SOFT_START_CYCLES),
  .SW_CHANNELS(SW_CHANNELS)
) u_bfps_sequencer_chk (
  .clock(clock), .rstn(rstn), .supply_lockout(supply_lockout),
  .overcurrent_compare(overcurrent_compare), .overvoltage_compare(overvoltage_compare),
  .over_temp_trip(over_temp_trip), .output_in_regulation(output_in_regulation),
  .upper_gate(upper_gate), .lower_gate(lower_gate), .linear_enable(linear_enable),
  .soft_start_active(soft_start_active), .power_good_out(power_good_out)
);

/* File: bfps_stage_model.sv */
// power stage and sense comparator model
`timescale 1ns/1ps
module bfps_stage_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic linear_enable,
  input wire logic [2:0] fault_oc,
  input wire logic [2:0] fault_ov,
  output logic [2:0] tick,
  output logic [2:0] oc,
  output logic [2:0] ov,
  output logic [3:0] in_regulation
);
  logic [1:0] phase_reg, phase_next;
  // four-clock switching period, rising tick ends a cycle
  always_comb begin
    phase_next = phase_reg + 2'h1;
  end
  always_ff @(posedge clock) begin
    phase_reg <= rstn ? phase_next : 2'h0;
  end
  // comparators follow commanded faults; rails settle only while enabled
  assign tick = {3{phase_reg[1]}};
  assign oc = fault_oc;
  assign ov = fault_ov;
  assign in_regulation = {4{linear_enable}};
endmodule // bfps_stage_model

/* File: bfps_sequencer_bench.sv */
// self-checking bench for the sequencer
`timescale 1ns/1ps
module bfps_sequencer_bench;
  localparam int SS = 20;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic supply_lockout = 1'h1;
  logic over_temp_trip = 1'h0;
  logic over_temp_cool = 1'h1;
  logic [2:0] pwm_request = 3'h5;
  logic [2:0] fault_oc = 3'h0;
  logic [2:0] fault_ov = 3'h0;
  logic [2:0] tick, oc, ov, upper_gate, lower_gate;
  logic [3:0] in_regulation;
  logic linear_enable, soft_start_active, power_good_out;
  logic [7:0] outs;
  int n_errors = 0;
  int checks = 0;
  int n;
  assign outs = {power_good_out, linear_enable, upper_gate, lower_gate};
  always #10 clock = ~clock;
  bfps_sequencer #(.SOFT_START_CYCLES(SS)) u_bfps_sequencer (
    .clock(clock), .rstn(rstn), .supply_lockout(supply_lockout),
    .switching_cycle_tick(tick), .overcurrent_compare(oc), .overvoltage_compare(ov),
    .over_temp_trip(over_temp_trip), .over_temp_cool(over_temp_cool),
    .output_in_regulation(in_regulation), .pwm_request(pwm_request),
    .upper_gate(upper_gate), .lower_gate(lower_gate), .linear_enable(linear_enable),
    .soft_start_active(soft_start_active), .power_good_out(power_good_out));
  bfps_stage_model u_bfps_stage_model (
    .clock(clock), .rstn(rstn), .linear_enable(linear_enable), .fault_oc(fault_oc),
    .fault_ov(fault_ov), .tick(tick), .oc(oc), .ov(ov), .in_regulation(in_regulation));
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic step(int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic wait_pg(int limit);
    n = 0;
    while (power_good_out !== 1'h1 && n < limit) begin
      step(1);
      n++;
    end
  endtask
  task automatic t_lockout;
    step(6);
    check(outs, 8'h00);
    supply_lockout = 1'h0;
    step(4);
    check(soft_start_active, 1'h1);
    wait_pg(4 * SS);
    check(n >= SS - 4, 1'h1);
    check(outs, 8'hEA);
  endtask
  // isolated detections must never add up
  task automatic t_oc_single;
    repeat (3) begin
      fault_oc = 3'h2;
      step(4);
      fault_oc = 3'h0;
      step(8);
    end
    check(outs, 8'hEA);
  endtask
  task automatic t_hiccup;
    fault_oc = 3'h1;
    step(16);
    check(outs, 8'h00);
    step(8 * SS);
    check({power_good_out, soft_start_active}, 8'h01);
    fault_oc = 3'h0;
    wait_pg(12 * SS);
    check(n > 4 * SS, 1'h1);
    check(outs, 8'hEA);
  endtask
  task automatic t_ss_oc;
    supply_lockout = 1'h1;
    step(6);
    supply_lockout = 1'h0;
    step(6);
    fault_oc = 3'h4;
    step(16);
    fault_oc = 3'h0;
    step(SS);
    check(outs, 8'h00);
    wait_pg(12 * SS);
    check(outs, 8'hEA);
  endtask
  task automatic t_ov;
    fault_ov = 3'h1;
    step(6);
    check(outs, 8'hE2);
    step(24);
    check(outs, 8'hE3);
    fault_ov = 3'h0;
    step(6);
    check(outs, 8'hEA);
  endtask
  task automatic t_thermal;
    over_temp_trip = 1'h1;
    over_temp_cool = 1'h0;
    step(6);
    check(outs, 8'h00);
    over_temp_trip = 1'h0;
    step(SS);
    check(outs, 8'h00);
    over_temp_cool = 1'h1;
    step(4);
    check(soft_start_active, 1'h1);
    wait_pg(4 * SS);
    check(outs, 8'hEA);
  endtask
  task automatic complete_run;
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    step(4);
    rstn = 1'h1;
    t_lockout;
    t_oc_single;
    t_hiccup;
    t_ss_oc;
    t_ov;
    t_thermal;
    complete_run;
  end
  // hang guard, several times the expected run
  initial begin
    #(20 * 5000);
    n_errors++;
    complete_run;
  end
endmodule // bfps_sequencer_bench
